/* logic/hisma_consts.vh */
// register offsets, field positions and reset values of the host interrupt block
// included by the interrupt block; definitions only
`ifndef HISMA_CONSTS_VH
`define HISMA_CONSTS_VH

`define HISMA_ADDR_W 8
// audio data windows
`define HISMA_OFF_AUD1_LO 8'h00
`define HISMA_OFF_AUD1_HI 8'h03
`define HISMA_OFF_AUD2_LO 8'h04
`define HISMA_OFF_AUD2_HI 8'h07
// audio data windows as four-byte window numbers
`define HISMA_WIN_AUD1 6'h00
`define HISMA_WIN_AUD2 6'h01
// hdlc shift-register windows, four bytes each, base upper bits
`define HISMA_WIN_HR1 6'h04
`define HISMA_WIN_HX1 6'h05
`define HISMA_WIN_HR2 6'h06
`define HISMA_WIN_HX2 6'h07
// interrupt status, acknowledge and mask
`define HISMA_OFF_HSTAT_LO 8'h70
`define HISMA_OFF_HSTAT_HI 8'h71
`define HISMA_OFF_LSTAT_LO 8'h72
`define HISMA_OFF_HACK_HI 8'h73
`define HISMA_OFF_LMASK_LO 8'h74
`define HISMA_OFF_LMASK_HI 8'h75
`define HISMA_OFF_HMASK_LO 8'h76
`define HISMA_OFF_HMASK_HI 8'h77
`define HISMA_OFF_LACK_LO 8'h78
`define HISMA_OFF_LACK_HI 8'h79
`define HISMA_OFF_LSTAT_HI 8'h7a
// high status word bit positions
`define HISMA_B_FSC 15
`define HISMA_B_RFS 14
`define HISMA_B_TFS 13
`define HISMA_B_RX1 7
`define HISMA_B_RX2 6
`define HISMA_B_TX1 5
`define HISMA_B_TX2 4
`define HISMA_B_HR1 3
`define HISMA_B_HX1 2
`define HISMA_B_HR2 1
`define HISMA_B_HX2 0
// low status word bit positions
`define HISMA_B_T1 15
`define HISMA_B_T2 14
`define HISMA_B_T3 13
`define HISMA_B_SAI 12
`define HISMA_B_IND 10
`define HISMA_B_HC1 9
`define HISMA_B_HC2 8
`define HISMA_B_MDR 7
`define HISMA_B_MER 6
`define HISMA_B_MDA 5
`define HISMA_B_MEA 4
`define HISMA_B_MAB 3
`define HISMA_B_GPI 2
`define HISMA_B_CI1 1
`define HISMA_B_CI2 0
// implemented bits and reset values
`define HISMA_HIGH_USED 16'he0ff
`define HISMA_LOW_USED 16'hf7ff
`define HISMA_MASK_RST 16'h0000
`define HISMA_STAT_RST 16'h0000

`endif

/* logic/hisma_intc.v */
// host interrupt status, mask and acknowledge for the parallel host port
// assumes a synchronous byte bus from the host port logic on clk_sys
// and one-cycle event pulses from the sources on the same clock
//
// Operation
// - frame sync, rx and tx frame sync flags sit in bits 15..13 at 0x71.
// - buffer flags at 0x70 bits 7..0: rx full, tx empty, hdlc ready.
// - writing any byte of 0x00-03 or 0x04-07 clears tx empty 1 or 2.
// - reading 0x00 or 0x04 clears rx full 1 or 2.
// - reading any byte of an hdlc window clears its ready flag.
// - mask bit zero blocks the line; all masks reset to zero.
// - flags set and hold regardless of mask; mask gates the line only.
// - writing one to 0x73 bits 15..13 clears the frame sync flags.
// - writing one to a low acknowledge bit clears that low flag.
// - low mask: timers, serial audio, indication, hdlc at 0x75; monitor, gpi, ci at 0x74.
// - reading the indication status register clears the indication flag.
// - reading an hdlc controller interrupt register clears its flag.
// - reading the monitor receive register clears monitor byte received.
// - reading the general input status register clears its flag.
// - reading a ci receive register clears its change flag.
// - a copy for the other processor is set by the same cause.
// - frame sync and buffer flags go high line; others go low line.
`timescale 1ns/10ps
`include "hisma_consts.vh"

module hisma_intc #(
    parameter ADDR_W = `HISMA_ADDR_W
) (
    clk_sys,
    sys_rst,
    clk_en,
    host_addr,
    host_wr,
    host_rd,
    host_wdata,
    host_rdata,
    hi_set,
    lo_set,
    ind_status_read,
    hdlc_one_irq_read,
    hdlc_two_irq_read,
    monitor_rx_register_read,
    general_status_read,
    ci_one_rx_register_read,
    ci_two_rx_register_read,
    high_stat_out,
    low_stat_out,
    high_priority_irq_line,
    low_priority_irq_line
);
    input wire clk_sys;
    input wire sys_rst;
    input wire clk_en;
    input wire [ADDR_W-1:0] host_addr;
    input wire host_wr;
    input wire host_rd;
    input wire [7:0] host_wdata;
    output reg [7:0] host_rdata;
    // set pulses, one bit per flag, in status word layout
    input wire [15:0] hi_set;
    input wire [15:0] lo_set;
    // read strobes from the indirect access engine and sub-blocks
    input wire ind_status_read;
    input wire hdlc_one_irq_read;
    input wire hdlc_two_irq_read;
    input wire monitor_rx_register_read;
    input wire general_status_read;
    input wire ci_one_rx_register_read;
    input wire ci_two_rx_register_read;
    // host-side flag copies for the dsp side mirror logic
    output wire [15:0] high_stat_out;
    output wire [15:0] low_stat_out;
    output reg high_priority_irq_line;
    output reg low_priority_irq_line;

    // flag and mask state
    reg [15:0] high_stat_reg;
    reg [15:0] low_stat_reg;
    reg [15:0] high_mask_reg;
    reg [15:0] low_mask_reg;
    // combinational terms feeding the state above
    reg [15:0] high_ack;
    reg [15:0] low_ack;
    reg [15:0] high_clr;
    reg [15:0] low_clr;
    reg [15:0] high_stat_next;
    reg [15:0] low_stat_next;
    reg [7:0] rdata_next;
    reg high_line_next;
    reg low_line_next;

    // byte address and qualified strobes; a frozen clock must not see accesses
    wire [7:0] a8 = host_addr[7:0];
    wire wr = clk_en & host_wr;
    wire rd = clk_en & host_rd;

    // true when the address falls in a four-byte window
    function in_win;
        input [7:0] addr;
        input [5:0] base;
        begin
            in_win = (addr[7:2] == base);
        end
    endfunction

    // true when the address names one register byte
    function at_off;
        input [7:0] addr;
        input [7:0] off;
        begin
            at_off = (addr == off);
        end
    endfunction

    // audio data: any byte written empties, only the base byte read drains
    wire aud1_wr = wr & in_win(a8, `HISMA_WIN_AUD1);
    wire aud2_wr = wr & in_win(a8, `HISMA_WIN_AUD2);
    wire aud1_rd = rd & at_off(a8, `HISMA_OFF_AUD1_LO);
    wire aud2_rd = rd & at_off(a8, `HISMA_OFF_AUD2_LO);

    // hdlc windows: 1, 2 and 4 byte reads all fall inside one window
    wire hr1_rd = rd & in_win(a8, `HISMA_WIN_HR1);
    wire hx1_rd = rd & in_win(a8, `HISMA_WIN_HX1);
    wire hr2_rd = rd & in_win(a8, `HISMA_WIN_HR2);
    wire hx2_rd = rd & in_win(a8, `HISMA_WIN_HX2);

    // acknowledge register writes
    wire hack_hi_wr = wr & at_off(a8, `HISMA_OFF_HACK_HI);
    wire lack_lo_wr = wr & at_off(a8, `HISMA_OFF_LACK_LO);
    wire lack_hi_wr = wr & at_off(a8, `HISMA_OFF_LACK_HI);

    // mask register writes
    wire lmask_lo_wr = wr & at_off(a8, `HISMA_OFF_LMASK_LO);
    wire lmask_hi_wr = wr & at_off(a8, `HISMA_OFF_LMASK_HI);
    wire hmask_lo_wr = wr & at_off(a8, `HISMA_OFF_HMASK_LO);
    wire hmask_hi_wr = wr & at_off(a8, `HISMA_OFF_HMASK_HI);

    // reads of reporting registers elsewhere; gated so a frozen clock drops them
    wire ind_clr = clk_en & ind_status_read;
    wire hc1_clr = clk_en & hdlc_one_irq_read;
    wire hc2_clr = clk_en & hdlc_two_irq_read;
    wire mdr_clr = clk_en & monitor_rx_register_read;
    wire gpi_clr = clk_en & general_status_read;
    wire ci1_clr = clk_en & ci_one_rx_register_read;
    wire ci2_clr = clk_en & ci_two_rx_register_read;

    // pending sources; the mask only gates the line, never the flag
    wire [15:0] high_pend = high_stat_reg & high_mask_reg;
    wire [15:0] low_pend = low_stat_reg & low_mask_reg;

    // high acknowledge: only ones clear, zero bits leave their flags alone
    always @* begin
        high_ack = 16'h0000;
        if (hack_hi_wr) begin
            high_ack[`HISMA_B_FSC] = host_wdata[`HISMA_B_FSC - 8];
            high_ack[`HISMA_B_RFS] = host_wdata[`HISMA_B_RFS - 8];
            high_ack[`HISMA_B_TFS] = host_wdata[`HISMA_B_TFS - 8];
        end
    end

    // low acknowledge, one byte at a time
    always @* begin
        low_ack = 16'h0000;
        if (lack_lo_wr) begin
            low_ack[7:0] = host_wdata;
        end
        if (lack_hi_wr) begin
            low_ack[15:8] = host_wdata;
        end
    end

    // high clear terms: acknowledges plus data register side effects
    always @* begin
        high_clr = high_ack;
        high_clr[`HISMA_B_RX1] = aud1_rd;
        high_clr[`HISMA_B_RX2] = aud2_rd;
        high_clr[`HISMA_B_TX1] = aud1_wr;
        high_clr[`HISMA_B_TX2] = aud2_wr;
        high_clr[`HISMA_B_HR1] = hr1_rd;
        high_clr[`HISMA_B_HX1] = hx1_rd;
        high_clr[`HISMA_B_HR2] = hr2_rd;
        high_clr[`HISMA_B_HX2] = hx2_rd;
    end

    // low clear terms: acknowledges plus reads of the reporting registers
    always @* begin
        low_clr = low_ack;
        low_clr[`HISMA_B_IND] = low_ack[`HISMA_B_IND] | ind_clr;
        low_clr[`HISMA_B_HC1] = low_ack[`HISMA_B_HC1] | hc1_clr;
        low_clr[`HISMA_B_HC2] = low_ack[`HISMA_B_HC2] | hc2_clr;
        low_clr[`HISMA_B_MDR] = low_ack[`HISMA_B_MDR] | mdr_clr;
        low_clr[`HISMA_B_GPI] = low_ack[`HISMA_B_GPI] | gpi_clr;
        low_clr[`HISMA_B_CI1] = low_ack[`HISMA_B_CI1] | ci1_clr;
        low_clr[`HISMA_B_CI2] = low_ack[`HISMA_B_CI2] | ci2_clr;
    end

    // next flags: set beats clear, so an event in the clearing cycle survives
    always @* begin
        high_stat_next = ((high_stat_reg & ~high_clr) | hi_set) & `HISMA_HIGH_USED;
        low_stat_next = ((low_stat_reg & ~low_clr) | lo_set) & `HISMA_LOW_USED;
    end

    // high flags; the mask plays no part here
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            high_stat_reg <= `HISMA_STAT_RST;
        end else if (clk_en) begin
            high_stat_reg <= high_stat_next;
        end
    end

    // low flags; bit 11 has no source and stays zero
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            low_stat_reg <= `HISMA_STAT_RST;
        end else if (clk_en) begin
            low_stat_reg <= low_stat_next;
        end
    end

    // low mask, cleared at reset so every source starts blocked
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            low_mask_reg <= `HISMA_MASK_RST;
        end else begin
            // unused bits stored as written; the host is expected to keep them zero
            if (lmask_lo_wr) begin
                low_mask_reg[7:0] <= host_wdata;
            end
            if (lmask_hi_wr) begin
                low_mask_reg[15:8] <= host_wdata;
            end
        end
    end

    // high mask; the high line stays quiet until the host opens it
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            high_mask_reg <= `HISMA_MASK_RST;
        end else begin
            if (hmask_lo_wr) begin
                high_mask_reg[7:0] <= host_wdata;
            end
            if (hmask_hi_wr) begin
                high_mask_reg[15:8] <= host_wdata;
            end
        end
    end

    // read mux; acknowledge registers and unmapped bytes read zero
    always @* begin
        case (a8)
            // interrupt status words
            `HISMA_OFF_HSTAT_LO: rdata_next = high_stat_reg[7:0];
            `HISMA_OFF_HSTAT_HI: rdata_next = high_stat_reg[15:8];
            `HISMA_OFF_LSTAT_LO: rdata_next = low_stat_reg[7:0];
            `HISMA_OFF_LSTAT_HI: rdata_next = low_stat_reg[15:8];
            // mask words read back as written
            `HISMA_OFF_LMASK_LO: rdata_next = low_mask_reg[7:0];
            `HISMA_OFF_LMASK_HI: rdata_next = low_mask_reg[15:8];
            `HISMA_OFF_HMASK_LO: rdata_next = high_mask_reg[7:0];
            `HISMA_OFF_HMASK_HI: rdata_next = high_mask_reg[15:8];
            // write-only acknowledge bytes fall here too
            default: rdata_next = 8'h00;
        endcase
    end

    // read data register; holds between reads so a slow host can pick it up
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            host_rdata <= 8'h00;
        end else if (rd) begin
            host_rdata <= rdata_next;
        end
    end

    // line terms; any pending source of the group raises its line
    always @* begin
        high_line_next = |high_pend;
        low_line_next = |low_pend;
    end

    // registered lines, one cycle behind the flags, glitch free at the pin
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            high_priority_irq_line <= 1'b0;
            low_priority_irq_line <= 1'b0;
        end else if (clk_en) begin
            high_priority_irq_line <= high_line_next;
            low_priority_irq_line <= low_line_next;
        end
    end

    // the dsp-side copy takes the same set pulses outside this block
    assign high_stat_out = high_stat_reg;
    assign low_stat_out = low_stat_reg;

endmodule // hisma_intc

/* test/hisma_intc_sva.sv */
// port assertions for the host interrupt status, mask and acknowledge block
// sees only the block's ports; mask registers are internal, so lines are checked one way
`timescale 1ns/10ps
module hisma_intc_sva (
    input wire clk_sys,
    input wire sys_rst,
    input wire clk_en,
    input wire [7:0] host_addr,
    input wire host_wr,
    input wire host_rd,
    input wire [7:0] host_wdata,
    input wire [15:0] hi_set,
    input wire [15:0] lo_set,
    input wire [15:0] high_stat_out,
    input wire [15:0] low_stat_out,
    input wire high_priority_irq_line,
    input wire low_priority_irq_line
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // accesses only count on enabled edges
    wire wr = clk_en && host_wr;
    wire rd = clk_en && host_rd;
    property p_fs_set; clk_en && hi_set[15] |=> high_stat_out[15]; endproperty
    a_fs_set: assert property (p_fs_set) else $error("frame sync flag missed");
    property p_hi_set; clk_en |=> ((high_stat_out & $past(hi_set)) == ($past(hi_set) & 16'he0ff)); endproperty
    a_hi_set: assert property (p_hi_set) else $error("high flag set lost");
    property p_tx_clr; wr && host_addr[7:3] == 5'h00 && !hi_set[5 - host_addr[2]] |=> !high_stat_out[5 - $past(host_addr[2])]; endproperty
    a_tx_clr: assert property (p_tx_clr) else $error("tx empty not cleared");
    property p_rx_clr; rd && host_addr[7:3] == 5'h00 && host_addr[1:0] == 2'h0 && !hi_set[7 - host_addr[2]] |=> !high_stat_out[7 - $past(host_addr[2])]; endproperty
    a_rx_clr: assert property (p_rx_clr) else $error("rx full not cleared");
    property p_hdlc_clr; rd && host_addr[7:4] == 4'h1 && !hi_set[3 - host_addr[3:2]] |=> !high_stat_out[3 - $past(host_addr[3:2])]; endproperty
    a_hdlc_clr: assert property (p_hdlc_clr) else $error("hdlc ready not cleared");
    property p_fs_ack; wr && host_addr == 8'h73 && host_wdata[7] && !hi_set[15] |=> !high_stat_out[15]; endproperty
    a_fs_ack: assert property (p_fs_ack) else $error("frame sync ack ignored");
    property p_lo_ack; wr && host_addr == 8'h78 |=> (low_stat_out[7:0] & $past(host_wdata & ~lo_set[7:0])) == 8'h00; endproperty
    a_lo_ack: assert property (p_lo_ack) else $error("low ack ignored");
    // high flags only fall on a host access
    property p_hold; !host_wr && !host_rd |=> (high_stat_out & $past(high_stat_out)) == $past(high_stat_out); endproperty
    a_hold: assert property (p_hold) else $error("high flag dropped");
    property p_hi_line; high_priority_irq_line |-> $past(|high_stat_out); endproperty
    a_hi_line: assert property (p_hi_line) else $error("high line without flag");
    property p_lo_line; low_priority_irq_line |-> $past(|low_stat_out); endproperty
    a_lo_line: assert property (p_lo_line) else $error("low line without flag");
    c_rd_stat: cover property (rd && host_addr == 8'h70);
    c_ack: cover property (wr && host_addr == 8'h73);
    c_line: cover property (high_priority_irq_line);
    c_lo_line: cover property (low_priority_irq_line);
endmodule // hisma_intc_sva

bind hisma_intc hisma_intc_sva u_sva (.*);

/* test/hisma_host.sv */
// host processor model on the byte bus of the interrupt block
// strobes change 1 ns after the rising edge and stand for one sampling edge
`timescale 1ns/10ps
module hisma_host (
    input wire clk_sys,
    output reg [7:0] host_addr,
    output reg host_wr,
    output reg host_rd,
    output reg [7:0] host_wdata
);
    // idle bus before the first access
    initial begin
        host_addr = 8'hff;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 8'h00;
    end
    // one access; writes to 0x75 go out with bit 3 clear, the unused low mask bit 11
    task access(input w, input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            #1;
            host_addr = a;
            host_wdata = (a == 8'h75) ? (d & 8'hf7) : d;
            host_wr = w;
            host_rd = !w;
            @(posedge clk_sys);
            #1;
            host_wr = 1'b0;
            host_rd = 1'b0;
            host_addr = ~a; // released bus, stale value not kept
            host_wdata = ~d;
        end
    endtask
endmodule // hisma_host

/* test/testbench.sv */
// self-checking bench for the host interrupt block
// read results queued by the driver, checked by the monitor one cycle later
`timescale 1ns/10ps
module testbench;
    reg clk_sys, sys_rst, clk_en, rd_seen;
    reg [15:0] hi_set, lo_set, v, a;
    reg [6:0] clr;
    reg [8:0] expq[$];
    wire [7:0] host_addr, host_wdata, host_rdata;
    wire host_wr, host_rd, high_priority_irq_line, low_priority_irq_line;
    wire [15:0] high_stat_out, low_stat_out;
    integer fail_count = 0, n_compared = 0, seed = 32'hace3, i;
    hisma_intc u_dut (.*, .ind_status_read(clr[6]), .hdlc_one_irq_read(clr[5]),
        .hdlc_two_irq_read(clr[4]), .monitor_rx_register_read(clr[3]),
        .general_status_read(clr[2]), .ci_one_rx_register_read(clr[1]),
        .ci_two_rx_register_read(clr[0]));
    hisma_host u_host (.*);
    task chk(input [7:0] e, input [7:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("wrong value at %0t: expected %h got %h", $time, e, g);
            end
        end
    endtask
    // bit 8 of a note marks a read whose data is not ours to judge
    task rd(input [7:0] ad, input [8:0] e);
        begin
            expq.push_back(e);
            u_host.access(1'b0, ad, 8'h00);
        end
    endtask
    task wr(input [7:0] ad, input [7:0] d);
        u_host.access(1'b1, ad, d);
    endtask
    task pulse(input [15:0] h, input [15:0] l, input [6:0] c);
        begin
            @(posedge clk_sys);
            #1;
            {hi_set, lo_set, clr} = {h, l, c};
            @(posedge clk_sys);
            #1;
            {hi_set, lo_set, clr} = 39'h0;
        end
    endtask
    // e holds the expected high line, then the expected low line
    task line_is(input [1:0] e);
        begin
            @(posedge clk_sys);
            #1;
            chk({6'h00, e}, {6'h00, high_priority_irq_line, low_priority_irq_line});
        end
    endtask
    task tally_and_finish;
        begin
            $display("compared %0d wrong %0d", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // read data is registered, so judge it on the edge after the read
    always @(posedge clk_sys) begin
        if (rd_seen && !expq[0][8])
            chk(expq[0][7:0], host_rdata);
        if (rd_seen)
            void'(expq.pop_front());
        rd_seen <= host_rd && clk_en;
    end
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #100000;
        fail_count = fail_count + 1;
        tally_and_finish;
    end
    initial begin
        {sys_rst, clk_en, rd_seen, hi_set, lo_set, clr} = {3'b110, 39'h0};
        repeat (8) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        for (i = 0; i < 4; i = i + 1) rd(8'h74 + i, 9'h000);
        rd(8'h71, 9'h000);
        pulse(16'he0ff, 16'h0000, 7'h00);
        rd(8'h71, 9'h0e0);
        rd(8'h70, 9'h0ff);
        rd(8'h00, 9'h100);
        rd(8'h70, 9'h07f);
        rd(8'h04, 9'h100);
        wr(8'h02, 8'h00);
        wr(8'h07, 8'h00);
        rd(8'h70, 9'h00f);
        for (i = 0; i < 4; i = i + 1) rd(8'h10 + 5 * i, 9'h100);
        rd(8'h70, 9'h000);
        wr(8'h73, 8'h00);
        wr(8'h73, 8'h40);
        rd(8'h71, 9'h0a0);
        line_is(2'b00);
        wr(8'h77, 8'h80);
        line_is(2'b10);
        wr(8'h73, 8'h80);
        line_is(2'b00);
        // set and ack land on the same edge
        fork
            wr(8'h73, 8'h20);
            pulse(16'h2000, 16'h0000, 7'h00);
        join
        rd(8'h71, 9'h020);
        clk_en = 1'b0;
        pulse(16'h8000, 16'h0000, 7'h00);
        clk_en = 1'b1;
        rd(8'h71, 9'h020);
        $display("high group test done");
        v = 16'h0000;
        for (i = 0; i < 4; i = i + 1) begin
            // flags left over from the last round stay set and stay expected
            v = v | ($random(seed) & 16'hf7ff);
            a = $random(seed);
            pulse(16'h0000, v, 7'h00);
            rd(8'h72, {1'b0, v[7:0]});
            rd(8'h7a, {1'b0, v[15:8]});
            wr(8'h78, a[7:0]);
            wr(8'h79, a[15:8]);
            v = v & ~a;
            pulse(16'h0000, 16'h0000, 7'h7f);
            v = v & ~16'h0787;
            rd(8'h72, {1'b0, v[7:0]});
            rd(8'h7a, {1'b0, v[15:8]});
        end
        $display("low group test done");
        wr(8'h75, 8'hff);
        rd(8'h75, 9'h0f7);
        wr(8'h74, 8'hff);
        rd(8'h74, 9'h0ff);
        wr(8'h78, 8'hff);
        wr(8'h79, 8'hff);
        pulse(16'h0000, 16'h1000, 7'h00);
        line_is(2'b01);
        wr(8'h79, 8'h10);
        line_is(2'b00);
        $display("low line test done");
        tally_and_finish;
    end
endmodule // testbench
